// [adc_control.sv]
// Control register, serial port and mode sequencer of the sigma-delta converter.
// What this block does
// - Select-low write loads the control register.
// - Select-low read shifts out the control register.
// - Partial control write is discarded entirely.
// - Clock pulses past the 24th are ignored.
// - Control field order: mode, gain, ..., notch.
// - Mode 000 normal, data read, reset default.
// - Mode 001 self calibration, then mode clears.
// - Mode 010 system zero-scale step, then normal.
// - Mode 011 system full-scale step, then normal.
// - Mode 100 system offset calibration, then normal.
// - Mode 101 background calibration, one-sixth rate.
// - Mode 110 accesses zero-scale coefficient.
// - Mode 111 accesses full-scale coefficient.
// - Coefficient transfers are always 24 bits.
// - Ready falls on new word, rises after readout.
// - Unipolar natural binary, bipolar offset binary.
`include "adc_defines.svh"
`timescale 1ns/1ns
`default_nettype none
module adc_control
    import adc_pkg::*;
(
    // Core clock and reset, synchronous in the core domain and asynchronous in the link domain.
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    // Serial link, clocked by the host's serial clock.
    input  wire logic        sclk,
    input  wire logic        write_frame_n,
    input  wire logic        read_frame_n,
    input  wire logic        register_select,
    input  wire logic        serial_io_in,
    output logic             serial_io_out,
    output logic             serial_io_oe_n,
    output logic             result_ready_n,
    // Filter results, two's complement, on the core clock.
    input  wire logic [23:0] sample_code,
    input  wire logic        sample_valid,
    // Settings to the analog front end.
    output logic [2:0]       gain_sel,
    output logic             channel_select,
    output logic             power_down_bit,
    output logic             word_length_bit,
    output logic             comp_current_en,
    output logic             burnout_current_enable,
    output logic             unipolar_sel,
    output logic [11:0]      notch_code,
    // Calibration source for the front end.
    output logic             cal_zero_active,
    output logic             cal_full_active,
    output logic             cal_internal
);

    ////////////////////////////////
    // Helper functions.

    // Coefficient index from scale kind and channel.
    function automatic caddr_t coef_addr(input logic full, input logic ch);
        coef_addr = {full, ch};
    endfunction : coef_addr

    // True for the two coefficient access modes.
    function automatic logic mode_is_coef(input mode_t m);
        mode_is_coef = (m == `MODE_ZS_COEF) || (m == `MODE_FS_COEF);
    endfunction : mode_is_coef

    // True for the modes that start a calibration sequence.
    function automatic logic mode_is_cal(input mode_t m);
        mode_is_cal = (m == `MODE_SELF) || (m == `MODE_SYS_ZERO) ||
                      (m == `MODE_SYS_FULL) || (m == `MODE_SYS_OFS);
    endfunction : mode_is_cal

    ////////////////////////////////
    // Link domain: write path.

    logic [4:0] wr_cnt_r;    // Bits received in this write frame.
    word_t      wr_shift_r;  // Incoming bits, most significant first.
    word_t      wr_word_r;   // Last complete word, held for the core.
    logic       wr_rs_r;     // Register select captured with that word.
    logic       wr_tog_r;    // Flips once per complete word.

    // The frame strobe clears the counter, because the serial clock stops between frames.
    always_ff @(posedge sclk or posedge write_frame_n) begin
        if (write_frame_n) begin
            wr_cnt_r   <= 5'h00;
            wr_shift_r <= '0;
        end else if (wr_cnt_r != `WORD_BITS) begin
            wr_cnt_r   <= wr_cnt_r + 5'h01;
            wr_shift_r <= {wr_shift_r[22:0], serial_io_in};
        end
    end

    // Only the 24th edge hands a word over; shorter frames never toggle.
    always_ff @(posedge sclk or negedge rst_b) begin
        if (!rst_b) begin
            wr_word_r <= '0;
            wr_rs_r   <= 1'b0;
            wr_tog_r  <= 1'b0;
        end else if (wr_cnt_r == `LAST_BIT) begin
            wr_word_r <= {wr_shift_r[22:0], serial_io_in};
            wr_rs_r   <= register_select;
            wr_tog_r  <= ~wr_tog_r;
        end
    end

    ////////////////////////////////
    // Link domain: read path.

    logic [4:0] rd_cnt_r;      // Bits sent in this read frame.
    logic       rd_tog_r;      // Flips once per complete data word sent.
    word_t      snap_word_r;   // Word to send, frozen while a read frame is open.
    logic [4:0] snap_len_r;    // Length of that word.
    logic       snap_data_r;   // The word is a conversion result.
    logic [4:0] tx_idx;        // Bit of the snapshot on the line.

    // Count bits sent; the frame strobe clears the count between frames.
    always_ff @(posedge sclk or posedge read_frame_n) begin
        if (read_frame_n) begin
            rd_cnt_r <= 5'h00;
        end else if (rd_cnt_r != `WORD_BITS) begin
            rd_cnt_r <= rd_cnt_r + 5'h01;
        end
    end

    // A full data word shifted out is the event that raises ready again.
    always_ff @(posedge sclk or negedge rst_b) begin
        if (!rst_b) begin
            rd_tog_r <= 1'b0;
        end else if (snap_data_r && (rd_cnt_r == snap_len_r - 5'h01)) begin
            rd_tog_r <= ~rd_tog_r;
        end
    end

    // Most significant bit first; the line idles low once all 24 bits are out.
    assign tx_idx         = `LAST_BIT - rd_cnt_r;
    assign serial_io_out  = (rd_cnt_r < `WORD_BITS) ? snap_word_r[tx_idx] : 1'b0;
    assign serial_io_oe_n = read_frame_n;

    ////////////////////////////////
    // Crossing into the core domain.

    logic [3:0] sync_q;      // Synchronised toggles, read strobe and select.
    logic       wr_seen_r;   // Last write toggle taken.
    logic       rd_seen_r;   // Last read toggle taken.
    logic       wr_evt;      // A complete word arrived.
    logic       rd_evt;      // A complete data word left.
    logic       rd_idle;     // No read frame open.
    logic       rs_sync;     // Register select, synchronised.

    level_sync #(
        .WIDTH     (4),
        .RESET_VAL (4'h2)
    ) u_sync (
        .clk   (core_clk),
        .rst_b (rst_b),
        .d     ({wr_tog_r, rd_tog_r, read_frame_n, register_select}),
        .q     (sync_q)
    );

    assign wr_evt  = sync_q[3] ^ wr_seen_r;
    assign rd_evt  = sync_q[2] ^ rd_seen_r;
    assign rd_idle = sync_q[1];
    assign rs_sync = sync_q[0];

    // Remember the toggles taken so each word counts once.
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            wr_seen_r <= 1'b0;
            rd_seen_r <= 1'b0;
        end else begin
            wr_seen_r <= sync_q[3];
            rd_seen_r <= sync_q[2];
        end
    end

    ////////////////////////////////
    // Control register and host decode.

    word_t      ctl_r;          // Control register.
    word_t      ctl_nxt;        // Its next value.
    mode_t      mode;           // Current mode field.
    mode_t      wr_mode;        // Mode field of the incoming word.
    logic       host_ctl_wr;    // Complete write to the control register.
    logic       host_coef_wr;   // Complete write to a coefficient.
    logic       cal_start;      // The new control word starts a calibration.
    logic       cal_done;       // The calibration sequence just ended.

    assign mode         = ctl_r[`MODE_MSB:`MODE_LSB];
    assign wr_mode      = wr_word_r[`MODE_MSB:`MODE_LSB];
    assign host_ctl_wr  = wr_evt && !wr_rs_r;
    assign host_coef_wr = wr_evt && wr_rs_r && mode_is_coef(mode);
    assign cal_start    = host_ctl_wr && mode_is_cal(wr_mode);

    // A host write wins; otherwise a finished calibration returns the mode to normal.
    always_comb begin
        ctl_nxt = ctl_r;
        if (host_ctl_wr) begin
            ctl_nxt = wr_word_r;
        end else if (cal_done) begin
            ctl_nxt[`MODE_MSB:`MODE_LSB] = `MODE_NORMAL;
        end
    end

    // Reset lands in normal mode with the documented defaults.
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            ctl_r <= `CTL_RESET;
        end else begin
            ctl_r <= ctl_nxt;
        end
    end

    ////////////////////////////////
    // Calibration sequencer.

    seq_state_t st_r;        // Current calibration step.
    seq_state_t st_nxt;      // Next step.
    logic       two_step;    // Zero step is followed by a full step.
    logic       bg_mode;     // Background calibration selected.
    logic [2:0] bg_slot_r;   // Slot of the next filter result in background mode.

    assign two_step = (mode == `MODE_SELF) || (mode == `MODE_SYS_OFS);
    assign bg_mode  = (mode == `MODE_BACKGND);
    assign cal_done = sample_valid && (((st_r == SEQ_ZERO) && !two_step) ||
                                       (st_r == SEQ_FULL));

    // Each calibration step consumes one filter result.
    always_comb begin
        st_nxt = st_r;
        case (st_r)
            SEQ_RUN: begin
                if (cal_start && (wr_mode == `MODE_SYS_FULL)) begin
                    st_nxt = SEQ_FULL;
                end else if (cal_start) begin
                    st_nxt = SEQ_ZERO;
                end
            end
            SEQ_ZERO: begin
                if (host_ctl_wr) begin
                    st_nxt = SEQ_RUN;
                end else if (sample_valid) begin
                    st_nxt = two_step ? SEQ_FULL : SEQ_RUN;
                end
            end
            SEQ_FULL: begin
                if (host_ctl_wr || sample_valid) begin
                    st_nxt = SEQ_RUN;
                end
            end
            default: begin
                st_nxt = SEQ_RUN;
            end
        endcase
    end

    // A host write during calibration aborts it; a new calibration then needs a fresh write.
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            st_r <= SEQ_RUN;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Six filter results make one output word in background mode.
    always_ff @(posedge core_clk) begin
        if (!rst_b || !bg_mode) begin
            bg_slot_r <= 3'h0;
        end else if (sample_valid && !ctl_r[`PWR_POS]) begin
            bg_slot_r <= (bg_slot_r == `BG_FULL_SLOT) ? 3'h0 : bg_slot_r + 3'h1;
        end
    end

    ////////////////////////////////
    // Coefficient store.

    coef_if cport ();        // Port to the coefficient store.
    logic   seq_cal_wr;      // Calibration step result.
    logic   bg_cal_wr;       // Background calibration result.
    logic   bg_full;         // Background slot is the full-scale one.

    assign seq_cal_wr = sample_valid && (st_r != SEQ_RUN);
    assign bg_full    = (bg_slot_r == `BG_FULL_SLOT);
    assign bg_cal_wr  = sample_valid && bg_mode && !ctl_r[`PWR_POS] &&
                        ((bg_slot_r == `BG_ZERO_SLOT) || bg_full);

    // Host writes only occur in access modes, where no calibration runs.
    assign cport.wr_en   = host_coef_wr || seq_cal_wr || bg_cal_wr;
    assign cport.wr_data = host_coef_wr ? wr_word_r : sample_code;
    assign cport.wr_addr = host_coef_wr ? coef_addr(mode == `MODE_FS_COEF, ctl_r[`CHN_POS]) :
                           seq_cal_wr   ? coef_addr(st_r == SEQ_FULL, ctl_r[`CHN_POS]) :
                                          coef_addr(bg_full, ctl_r[`CHN_POS]);
    assign cport.rd_addr = coef_addr(mode == `MODE_FS_COEF, ctl_r[`CHN_POS]);

    coef_mem #(
        .DEPTH (4)
    ) u_coef (
        .core_clk (core_clk),
        .port     (cport.mem)
    );

    ////////////////////////////////
    // Conversion results and ready.

    word_t data_r;      // Data register.
    word_t coded;       // Filter result in the selected coding.
    logic  conv_out;    // A new output word is produced.
    logic  ready_n_nxt; // Next value of the ready output.

    // Unipolar is natural binary with negative inputs clamped; bipolar is offset binary.
    assign coded = ctl_r[`BU_POS] ?
                   (sample_code[23] ? 24'h000000 : {sample_code[22:0], 1'b0}) :
                   {~sample_code[23], sample_code[22:0]};

    assign conv_out = sample_valid && (st_r == SEQ_RUN) && !ctl_r[`PWR_POS] &&
                      (!bg_mode || (bg_slot_r == `BG_LAST_CONV));

    // A new word or a finished calibration pulls ready low and wins over a read that ends.
    assign ready_n_nxt = (conv_out || cal_done) ? 1'b0 :
                         (cal_start || rd_evt)   ? 1'b1 :
                                                   result_ready_n;

    // Data register and ready output.
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            data_r         <= '0;
            result_ready_n <= 1'b1;
        end else begin
            data_r         <= conv_out ? coded : data_r;
            result_ready_n <= ready_n_nxt;
        end
    end

    ////////////////////////////////
    // Read snapshot for the link.

    word_t      rd_sel_word;  // Word the current select and mode point at.
    logic       rd_sel_data;  // That word is the data register.
    logic [4:0] rd_sel_len;   // Its length in bits.

    assign rd_sel_data = rs_sync && !mode_is_coef(mode);
    assign rd_sel_word = !rs_sync          ? ctl_r :
                         mode_is_coef(mode) ? cport.rd_data :
                                              data_r;
    assign rd_sel_len  = (rd_sel_data && !ctl_r[`WLN_POS]) ? `SHORT_BITS : `WORD_BITS;

    // The snapshot only moves while no read frame is open, so the link sees stable bits.
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            snap_word_r <= '0;
            snap_len_r  <= `WORD_BITS;
            snap_data_r <= 1'b0;
        end else if (rd_idle) begin
            snap_word_r <= rd_sel_word;
            snap_len_r  <= rd_sel_len;
            snap_data_r <= rd_sel_data;
        end
    end

    ////////////////////////////////
    // Settings and calibration source to the front end.

    assign gain_sel               = ctl_r[`GAIN_MSB:`GAIN_LSB];
    assign channel_select         = ctl_r[`CHN_POS];
    assign power_down_bit         = ctl_r[`PWR_POS];
    assign word_length_bit        = ctl_r[`WLN_POS];
    assign comp_current_en        = ctl_r[`IO_POS];
    assign burnout_current_enable = ctl_r[`BRN_POS];
    assign unipolar_sel           = ctl_r[`BU_POS];
    assign notch_code             = ctl_r[`NOTCH_MSB:`NOTCH_LSB];

    // Self calibration and the background slots use shorted inputs and the reference.
    assign cal_zero_active = (st_r == SEQ_ZERO) || (bg_mode && (bg_slot_r == `BG_ZERO_SLOT));
    assign cal_full_active = (st_r == SEQ_FULL) || (bg_mode && bg_full);
    assign cal_internal    = (mode == `MODE_SELF) || bg_mode ||
                             ((mode == `MODE_SYS_OFS) && (st_r == SEQ_FULL));

endmodule : adc_control
`default_nettype wire

// [adc_defines.svh]
// Constants of the converter control block: offsets, field positions, reset values, counts.
`ifndef ADC_DEFINES_SVH
`define ADC_DEFINES_SVH

// Word sizes of the serial port.
`define CTL_W          24
`define WORD_BITS      5'd24
`define SHORT_BITS     5'd16
`define LAST_BIT       5'd23

// Field positions inside the control word, most significant first.
`define MODE_MSB       23
`define MODE_LSB       21
`define GAIN_MSB       20
`define GAIN_LSB       18
`define CHN_POS        17
`define PWR_POS        16
`define WLN_POS        15
`define IO_POS         14
`define BRN_POS        13
`define BU_POS         12
`define NOTCH_MSB      11
`define NOTCH_LSB      0

// Reset value of the control word: normal mode, gain 1, first channel, 16-bit, bipolar.
`define CTL_RESET      24'h0000C8

// Operating mode codes.
`define MODE_NORMAL    3'h0
`define MODE_SELF      3'h1
`define MODE_SYS_ZERO  3'h2
`define MODE_SYS_FULL  3'h3
`define MODE_SYS_OFS   3'h4
`define MODE_BACKGND   3'h5
`define MODE_ZS_COEF   3'h6
`define MODE_FS_COEF   3'h7

// Background calibration slots: four conversions, then zero and full calibration.
`define BG_LAST_CONV   3'h3
`define BG_ZERO_SLOT   3'h4
`define BG_FULL_SLOT   3'h5

`endif

// [adc_pkg.sv]
// Types shared by the converter control block.
package adc_pkg;
    typedef logic [23:0] word_t;   // One serial word.
    typedef logic [2:0]  mode_t;   // Operating mode field.
    typedef logic [1:0]  caddr_t;  // Coefficient index: {full, channel}.
    typedef enum logic [1:0] {SEQ_RUN, SEQ_ZERO, SEQ_FULL} seq_state_t;  // Calibration steps.
endpackage : adc_pkg

// [coef_if.sv]
// Port bundle between the control logic and the coefficient store.
`timescale 1ns/1ns
`default_nettype none
interface coef_if;
    import adc_pkg::*;
    logic   wr_en;    // Write strobe.
    caddr_t wr_addr;  // Write index.
    word_t  wr_data;  // Write data.
    caddr_t rd_addr;  // Read index.
    word_t  rd_data;  // Registered read data.
    modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
    modport mem  (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface : coef_if
`default_nettype wire

// [level_sync.sv]
// Two-flop synchroniser for a group of slow levels.
`timescale 1ns/1ns
`default_nettype none
module level_sync #(
    parameter int            WIDTH     = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    // Clock and reset.
    input  wire logic             clk,
    input  wire logic             rst_b,
    // Levels in and out.
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_r;  // First stage, read only by the second.

    // Both stages reset to the idle level so no false event appears.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            meta_r <= RESET_VAL;
            q      <= RESET_VAL;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule : level_sync
`default_nettype wire

// [coef_mem.sv]
// Calibration coefficient store: zero and full scale for each channel.
`timescale 1ns/1ns
`default_nettype none
module coef_mem
    import adc_pkg::*;
#(
    parameter int DEPTH = 4
) (
    // Clock.
    input  wire logic core_clk,
    // Access port.
    coef_if.mem       port
);
    word_t words [DEPTH];  // Coefficient words, contents undefined until calibrated or written.

    // One write port and a registered read, so the read word is a flop output.
    always_ff @(posedge core_clk) begin
        if (port.wr_en) begin
            words[port.wr_addr] <= port.wr_data;
        end
        port.rd_data <= words[port.rd_addr];
    end
endmodule : coef_mem
`default_nettype wire

// [adc_control_sva.sv]
// Checker of the converter control block, bound to its top module.
`timescale 1ns/1ns
`default_nettype none
module adc_control_sva (
    // Clocks and reset.
    input wire logic        core_clk,
    input wire logic        sclk,
    input wire logic        rst_b,
    // Watched ports.
    input wire logic        write_frame_n,
    input wire logic        read_frame_n,
    input wire logic        serial_io_oe_n,
    input wire logic        result_ready_n,
    input wire logic        sample_valid,
    input wire logic [2:0]  gain_sel,
    input wire logic [11:0] notch_code,
    input wire logic        cal_zero_active,
    input wire logic        cal_full_active
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    ////////////////////////////////////////
    wire logic  cal_on = cal_zero_active | cal_full_active;  // Any calibration step running.
    logic [3:0] idle_r;  // Cycles since the write strobe rose; saturates so it never wraps.
    // The write word lands a few cycles after the frame, so only a long idle proves stability.
    always_ff @(posedge core_clk) begin
        idle_r <= (!rst_b || !write_frame_n) ? 4'h0 : idle_r + {3'h0, idle_r != 4'hF};
    end
    sequence s_step_end;
        cal_on ##1 !cal_on;
    endsequence
    sequence s_cal_two;
        cal_on ##1 cal_on;
    endsequence
    ////////////////////////////////////////
    a_oe_follows_frame: assert property (serial_io_oe_n == read_frame_n)
        else $error("oe not following frame");
    a_reset_defaults: assert property (disable iff (1'b0) !rst_b |=>
        result_ready_n && gain_sel == 3'h0 && notch_code == 12'h0C8)
        else $error("reset values wrong");
    a_fields_hold: assert property (idle_r == 4'hF |-> $stable({gain_sel, notch_code}))
        else $error("settings moved");
    a_cal_ready_high: assert property (s_cal_two |-> !$fell(result_ready_n))
        else $error("ready fell inside a calibration");
    a_cal_exclusive: assert property (!(cal_zero_active && cal_full_active))
        else $error("both cal steps active");
    a_step_sample: assert property (s_step_end |-> $past(sample_valid))
        else $error("calibration ended without a sample");
    a_cal_hold: assert property (cal_on && !sample_valid && idle_r == 4'hF |=>
        $stable({cal_zero_active, cal_full_active}))
        else $error("cal step moved");
    a_ready_fall_cause: assert property ($fell(result_ready_n) |-> $past(sample_valid))
        else $error("ready fell without a new result");
endmodule : adc_control_sva
bind adc_control adc_control_sva i_adc_control_sva (.core_clk, .sclk, .rst_b, .write_frame_n,
    .read_frame_n, .serial_io_oe_n, .result_ready_n, .sample_valid, .gain_sel, .notch_code,
    .cal_zero_active, .cal_full_active);
`default_nettype wire

// [host_model.sv]
// Host microcontroller model driving the converter's serial port.
`timescale 1ns/1ns
`default_nettype none
module host_model
    import adc_pkg::*;
(
    // Serial link towards the device.
    output logic      sclk,
    output logic      write_frame_n,
    output logic      read_frame_n,
    output logic      register_select,
    output logic      serial_io_in,
    // Device answer.
    input  wire logic serial_io_out,
    input  wire logic serial_io_oe_n
);
    word_t rd_word;  // Last word read, first bit highest.
    event  got;      // Fires when a read word is complete.
    initial begin
        {sclk, write_frame_n, read_frame_n, register_select, serial_io_in} = 5'h0C;
    end
    // One frame of n clocks at 15 ns; the clock stands still outside frames.
    task automatic xfer(input logic rd, input logic sel, input int n, input word_t d);
        #3 register_select = sel;
        #60;
        if (rd) read_frame_n = 1'b0;
        else write_frame_n = 1'b0;
        rd_word = '0;
        for (int k = 0; k < n; k++) begin
            serial_io_in = (k < 24) ? d[23 - k] : k[0];
            #8 rd_word = {rd_word[22:0], serial_io_out};
            sclk = 1'b1;
            #7 sclk = 1'b0;
        end
        #8 read_frame_n = 1'b1;
        write_frame_n = 1'b1;
        serial_io_in = ~serial_io_in;  // A released line never keeps its last bit.
        if (rd) ->got;
        #100;
    endtask : xfer
endmodule : host_model
`default_nettype wire

// [adc_control_register_modes_bench.sv]
// Self-checking bench of the converter control block.
`timescale 1ns/1ns
`default_nettype none
module adc_control_register_modes_bench;
    import adc_pkg::*;
    typedef struct {string name; word_t exp;} note_t;
    logic  core_clk = 1'b0, rst_b = 1'b0, sample_valid = 1'b0;
    word_t sample_code = '0, w, c, s;
    wire logic sclk, write_frame_n, read_frame_n, register_select, serial_io_in;
    wire logic serial_io_out, serial_io_oe_n, result_ready_n, cal_zero_active, cal_full_active;
    wire logic channel_select, power_down_bit, word_length_bit, comp_current_en;
    wire logic burnout_current_enable, unipolar_sel;
    wire logic [2:0]  gain_sel;
    wire logic [11:0] notch_code;
    int    failures = 0, samples_checked = 0, seed = 32'h2804, k, j;
    note_t notes[$];  // Expected read words, oldest first.
    always #5 core_clk = ~core_clk;
    host_model i_host_model (.sclk, .write_frame_n, .read_frame_n, .register_select,
        .serial_io_in, .serial_io_out, .serial_io_oe_n);
    adc_control i_adc_control (.core_clk, .rst_b, .sclk, .write_frame_n, .read_frame_n,
        .register_select, .serial_io_in, .serial_io_out, .serial_io_oe_n, .result_ready_n,
        .sample_code, .sample_valid, .gain_sel, .channel_select, .power_down_bit,
        .word_length_bit, .comp_current_en, .burnout_current_enable, .unipolar_sel,
        .notch_code, .cal_zero_active, .cal_full_active, .cal_internal());
    ////////////////////////////////////////
    task automatic check(string nm, word_t e, word_t v);
        samples_checked++;
        if (v !== e) begin
            failures++;
            $display("mismatch %s expected %h seen %h", nm, e, v);
        end
    endtask : check
    task automatic rd(string nm, logic sel, int n, word_t e);
        notes.push_back('{nm, e});
        i_host_model.xfer(1'b1, sel, n, '0);
    endtask : rd
    task automatic wr(logic sel, int n, word_t d);
        i_host_model.xfer(1'b0, sel, n, d);
    endtask : wr
    function automatic word_t ctl(mode_t m, logic ch, logic unip);
        return {m, 3'h0, ch, 4'h0, unip, 12'h0C8};
    endfunction : ctl
    task automatic pulse(word_t code);
        @(posedge core_clk) #1 sample_code = code;
        sample_valid = 1'b1;
        @(posedge core_clk) #1 sample_valid = 1'b0;
    endtask : pulse
    task automatic report_and_stop();
        $display("checked %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : report_and_stop
    // The watcher pairs each finished read with the oldest expectation.
    always @(i_host_model.got) begin : watch
        note_t n;
        n = notes.pop_front();
        check(n.name, n.exp, i_host_model.rd_word);
    end
    initial begin
        #300000 failures++;
        report_and_stop();
    end
    ////////////////////////////////////////
    initial begin
        repeat (6) @(posedge core_clk);
        #1 rst_b = 1'b1;
        repeat (3) @(posedge core_clk);
        rd("ctl_reset", 1'b0, 24, 24'h0000C8);
        for (k = 0; k < 4; k++) begin
            s = word_t'($random(seed));
            w = {3'h0, s[20:12], 12'd19 + s[11:0] % 12'd1982};
            wr(1'b0, k[0] ? 30 : 24, w);
            check("fields", w, {3'h0, gain_sel, channel_select, power_down_bit, word_length_bit,
                comp_current_en, burnout_current_enable, unipolar_sel, notch_code});
            wr(1'b0, 12, ~w);
            rd("ctl_word", 1'b0, 24, w);
        end
        $display("test control done");
        for (k = 0; k < 4; k++) begin
            c = word_t'($random(seed));
            wr(1'b0, 24, ctl(k[1] ? 3'h7 : 3'h6, k[0], 1'b0));
            wr(1'b1, 24, c);
            wr(1'b1, 20, ~c);
            rd("coef", 1'b1, 24, c);
        end
        $display("test coefficients done");
        for (k = 1; k < 5; k++) begin
            s = word_t'($random(seed));
            wr(1'b0, 24, ctl(mode_t'(k), 1'b0, 1'b0));
            check("ready_cal", 24'h1, {23'h0, result_ready_n});
            for (j = 0; j < 4 && result_ready_n; j++) pulse(s + word_t'(j));
            check("cal_steps", word_t'((k == 1 || k == 4) ? 2 : 1), word_t'(j));
            rd("mode_cleared", 1'b0, 24, ctl(3'h0, 1'b0, 1'b0));
        end
        wr(1'b0, 24, ctl(3'h6, 1'b0, 1'b0));
        rd("zero_coef", 1'b1, 24, s);
        wr(1'b0, 24, ctl(3'h7, 1'b0, 1'b0));
        rd("full_coef", 1'b1, 24, s + 24'h1);
        $display("test calibration done");
        for (k = 0; k < 3; k++) begin
            s = word_t'($random(seed));
            s[23] = (k != 2);
            wr(1'b0, 24, ctl(3'h0, 1'b0, k > 0));
            pulse(s);
            check("ready_new", 24'h0, {23'h0, result_ready_n});
            w = (k == 0) ? {8'h00, ~s[23], s[22:8]} : (k == 1) ? 24'h0 : {8'h00, s[22:7]};
            rd("data", 1'b1, 16, w);
            check("ready_read", 24'h1, {23'h0, result_ready_n});
        end
        $display("test conversion done");
        wr(1'b0, 24, ctl(3'h5, 1'b0, 1'b1));
        for (j = 0; j < 8 && result_ready_n; j++) pulse(s);
        rd("bg_data", 1'b1, 16, {8'h00, s[22:7]});
        for (j = 0; j < 8 && result_ready_n; j++) pulse(s);
        check("bg_rate", 24'd6, word_t'(j));
        $display("test background done");
        report_and_stop();
    end
endmodule : adc_control_register_modes_bench
`default_nettype wire
